// file: logic/abx_decode.sv
// Purpose: Classify one instruction word into an operation and its operands
// Assumes: Word is stable while its valid strobe is high
// Notes: Pure combinational; the caller uses it unregistered, addr drives rd_addr directly
`default_nettype none
module abx_decode (
  input wire logic [11:0] insn,
  output abx_pkg::abx_op_t op,
  output logic [4:0] addr,
  output logic [2:0] bit_sel,
  output logic dest_reg
);
  always_comb begin
    addr = insn[abx_pkg::ADDR_LSB +: abx_pkg::ADDR_W];
    bit_sel = insn[abx_pkg::BIT_LSB +: abx_pkg::BIT_W];
    dest_reg = insn[abx_pkg::DEST_POS];
    if (insn[11:6] == abx_pkg::OP_AND_ACC_INTO_REG) begin
      op = abx_pkg::ABX_OP_AND;
    end else begin
      case (insn[11:8])
        abx_pkg::OP_BIT_CLEAR: op = abx_pkg::ABX_OP_BCLR;
        abx_pkg::OP_BIT_SET: op = abx_pkg::ABX_OP_BSET;
        abx_pkg::OP_TEST_SKIP_IF_LOW: op = abx_pkg::ABX_OP_BTEST;
        default: op = abx_pkg::ABX_OP_NONE;
      endcase
    end
  end
endmodule : abx_decode
`default_nettype wire

// file: logic/abx_exec.sv
// Purpose: Execute the AND-with-register, bit clear, bit set and test-skip ops
// Assumes: File register read data is combinational on rd_addr in the same cycle
// Notes: One instruction per enabled cycle; a taken skip voids the next word
//   rd_addr is the only output not from a flip-flop, as the file answers at once
//   Bit ops are read-modify-write, so the file must not change under them
//   Unknown words write nothing but still pulse busy_q
`default_nettype none
// Function
// - AND accumulator with addressed register; only the zero flag changes.
// - Destination bit 0: result goes to accumulator, register untouched.
// - Destination bit 1: result goes to register, accumulator untouched.
// - Bit clear/set use 5-bit address and 3-bit index; no flags touched.
// - Test-skip: selected bit low skips next instruction, high continues.
// - Taken skip discards prefetched word and runs a no-op instead.
module abx_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction word from the fetch pipeline
  input wire logic insn_valid,
  input wire logic [11:0] insn,
  // File register array, read side combinational
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Accumulator seed from the core
  input wire logic [7:0] acc_init,
  input wire logic acc_load,
  output logic [7:0] acc_q,
  // Status and write-back request
  output logic zero_q,
  output logic zero_we_q,
  output logic wr_en_q,
  output logic [4:0] wr_addr_q,
  output logic [7:0] wr_data_q,
  // Sequencing
  output logic skip_q,
  output logic busy_q
);
  abx_pkg::abx_op_t op;
  logic [4:0] addr;
  logic [2:0] bit_sel;
  logic dest_reg;

  logic exec_now;
  logic do_and;
  logic do_bclr;
  logic do_bset;
  logic do_btest;

  logic [7:0] and_res;
  logic and_zero;
  logic [7:0] bit_mask;
  logic [7:0] bit_hit;
  logic [7:0] clr_res;
  logic [7:0] set_res;
  logic [7:0] reg_res;

  logic sel_bit;
  logic skip_take;
  logic acc_upd;
  logic reg_upd;

  abx_decode u_decode (
    .insn(insn),
    .op(op),
    .addr(addr),
    .bit_sel(bit_sel),
    .dest_reg(dest_reg)
  );

  // Read address follows the word; the file answers in the same cycle
  assign rd_addr = addr;

  // Word arriving while a skip is pending is the prefetched one and is voided
  assign exec_now = insn_valid && !skip_q;

  // One qualifier per op, all low for a voided or unknown word
  always_comb begin
    do_and = 1'h0;
    do_bclr = 1'h0;
    do_bset = 1'h0;
    do_btest = 1'h0;
    if (exec_now) begin
      case (op)
        abx_pkg::ABX_OP_AND: begin
          do_and = 1'h1;
        end
        abx_pkg::ABX_OP_BCLR: begin
          do_bclr = 1'h1;
        end
        abx_pkg::ABX_OP_BSET: begin
          do_bset = 1'h1;
        end
        abx_pkg::ABX_OP_BTEST: begin
          do_btest = 1'h1;
        end
        default: begin
          // Unknown words: no write, no flag, no skip
        end
      endcase
    end
  end

  assign and_res = acc_q & rd_data;
  assign and_zero = (and_res == 8'h00);

  // Mask, test and read-modify-write results, one slice per data bit
  for (genvar i = 0; i < abx_pkg::DATA_W; i++) begin : g_bit
    assign bit_mask[i] = (bit_sel == 3'(i));
    assign bit_hit[i] = rd_data[i] & bit_mask[i];
    assign clr_res[i] = rd_data[i] & ~bit_mask[i];
    assign set_res[i] = rd_data[i] | bit_mask[i];
  end

  assign sel_bit = |bit_hit;
  assign skip_take = do_btest && !sel_bit;

  // Only the AND op with destination 0 touches the accumulator
  assign acc_upd = do_and && !dest_reg;
  assign reg_upd = (do_and && dest_reg) || do_bclr || do_bset;

  // Value sent back to the file; only meaningful while reg_upd is high
  always_comb begin
    reg_res = rd_data;
    case (op)
      abx_pkg::ABX_OP_AND: begin
        reg_res = and_res;
      end
      abx_pkg::ABX_OP_BCLR: begin
        reg_res = clr_res;
      end
      abx_pkg::ABX_OP_BSET: begin
        reg_res = set_res;
      end
      default: begin
        reg_res = rd_data;
      end
    endcase
  end

  // A load from the core wins over the op in hand
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= abx_pkg::ACC_RESET;
    end else if (acc_load) begin
      acc_q <= acc_init;
    end else if (acc_upd) begin
      acc_q <= and_res;
    end
  end

  // Zero flag; bit ops leave it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_q <= abx_pkg::ZERO_RESET;
    end else if (do_and) begin
      zero_q <= and_zero;
    end
  end

  // Flag update strobe, one cycle after the AND
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_we_q <= 1'h0;
    end else begin
      zero_we_q <= do_and;
    end
  end

  // Write request stands one cycle, one cycle after its op
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en_q <= 1'h0;
    end else if (reg_upd) begin
      wr_en_q <= 1'h1;
    end else begin
      wr_en_q <= 1'h0;
    end
  end

  // Address and data hold their last value between requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_addr_q <= abx_pkg::ADDR_RESET;
    end else if (reg_upd) begin
      wr_addr_q <= addr;
    end
  end

  // Data is the AND result or the read word with one bit forced
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_data_q <= abx_pkg::DATA_RESET;
    end else if (reg_upd) begin
      wr_data_q <= reg_res;
    end
  end

  // Skip holds over idle cycles until the next word arrives and is voided
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'h0;
    end else if (insn_valid) begin
      if (skip_take) begin
        skip_q <= 1'h1;
      end else begin
        skip_q <= 1'h0;
      end
    end
  end

  // Busy marks a word that was executed, not voided
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'h0;
    end else begin
      busy_q <= exec_now;
    end
  end
endmodule : abx_exec
`default_nettype wire

// file: logic/abx_pkg.sv
// Purpose: Shared constants for the AND and bit-operation execution block
// Assumes: 12-bit instruction words, 8-bit data, 5-bit file addresses
// Notes: Opcode fields are matched on the top bits of the instruction word
`default_nettype none
package abx_pkg;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned BIT_W = 3;
  // Field positions in the instruction word
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned DEST_POS = 5;
  localparam int unsigned BIT_LSB = 5;
  // Opcode prefixes
  localparam logic [5:0] OP_AND_ACC_INTO_REG = 6'h05;
  localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
  localparam logic [3:0] OP_BIT_SET = 4'h5;
  localparam logic [3:0] OP_TEST_SKIP_IF_LOW = 4'h6;
  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic ZERO_RESET = 1'b0;
  typedef enum logic [2:0] {
    ABX_OP_NONE,
    ABX_OP_AND,
    ABX_OP_BCLR,
    ABX_OP_BSET,
    ABX_OP_BTEST
  } abx_op_t;
endpackage : abx_pkg
`default_nettype wire

// file: test/abx_exec_asserts.sv
// Purpose: Port checker
// Assumes: One clock
// Notes: Bound from the bench
`default_nettype none
module abx_exec_asserts (
  input wire logic clk, rst, insn_valid, acc_load, zero_q, zero_we_q, wr_en_q, skip_q, busy_q,
  input wire logic [11:0] insn,
  input wire logic [7:0] rd_data, acc_q, wr_data_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = insn_valid && !skip_q && !acc_load;
  wire is_and = tk && insn[11:6] == 6'h05;
  wire [3:0] op = tk ? insn[11:8] : 4'h0;
  wire [7:0] bm = 8'h01 << insn[7:5];
  wire [7:0] res = rd_data & acc_q;
  a_and_zero: assert property (
    is_and |=> zero_we_q && zero_q == ($past(res) == 8'h00)) else $error("zero flag");
  a_acc_dest: assert property (
    is_and && !insn[5] |=> acc_q == $past(res) && !wr_en_q) else $error("acc dest");
  a_reg_dest: assert property (
    is_and && insn[5] |=> wr_en_q && wr_data_q == $past(res) && $stable(acc_q))
    else $error("reg dest");
  a_bit_ops: assert property (
    op[3:1] == 3'h2 |=> wr_en_q && !zero_we_q
      && wr_data_q == $past(op[0] ? rd_data | bm : rd_data & ~bm)) else $error("bit op");
  a_skip_test: assert property (
    op == 4'h6 |=> skip_q == !$past(|(rd_data & bm))) else $error("skip");
  a_void_word: assert property (
    skip_q && insn_valid |=> !(wr_en_q || zero_we_q || busy_q || skip_q)) else $error("void");
  a_one_cycle: assert property (
    is_and || op inside {4'h4, 4'h5, 4'h6} |=> busy_q) else $error("busy");
  c_skip: cover property (skip_q && insn_valid);
  c_write: cover property (wr_en_q);
  c_zero: cover property (zero_we_q && zero_q);
endmodule : abx_exec_asserts
`default_nettype wire

// file: test/abx_regs.sv
// Purpose: File register model
// Assumes: Read is combinational
// Notes: Reset seeds index xor a5
`default_nettype none
module abx_regs (
  input wire logic clk, rst, wr_en_q,
  input wire logic [4:0] rd_addr, wr_addr_q,
  input wire logic [7:0] wr_data_q,
  output logic [7:0] rd_data
);
  logic [7:0] mem [32];
  assign rd_data = mem[rd_addr];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) for (int i = 0; i < 32; i++) mem[i] <= 8'(i) ^ 8'ha5;
    else if (wr_en_q) mem[wr_addr_q] <= wr_data_q;
  end
endmodule : abx_regs
`default_nettype wire

// file: test/tb_and_bit_ops_exec.sv
// Purpose: Bench
// Assumes: Falling edge drive
// Notes: Expected data from the model
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_and_bit_ops_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, insn_valid = 0, acc_load = 0, zero_q, zero_we_q, wr_en_q, skip_q, busy_q;
  logic [11:0] insn = 0;
  logic [7:0] acc_init = 0, rd_data, acc_q, wr_data_q, m;
  logic [4:0] rd_addr, wr_addr_q;
  int mismatches = 0, n_tests = 0, cyc = 0;
  always #12.5 clk = ~clk;
  abx_exec i_abx_exec (
    .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .rd_addr(rd_addr), .rd_data(rd_data), .acc_init(acc_init), .acc_load(acc_load),
    .acc_q(acc_q), .zero_q(zero_q), .zero_we_q(zero_we_q), .wr_en_q(wr_en_q),
    .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .skip_q(skip_q), .busy_q(busy_q)
  );
  abx_regs i_abx_regs (
    .clk(clk), .rst(rst), .wr_en_q(wr_en_q), .rd_addr(rd_addr),
    .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q), .rd_data(rd_data)
  );
  task automatic issue(input logic [11:0] w);
    @(negedge clk);
    {insn, insn_valid, acc_load} = {w, 2'h2};
    m = i_abx_regs.mem[w[4:0]];
    @(negedge clk);
    insn_valid = 0;
  endtask : issue
  task automatic t_and(input logic [7:0] a, input logic d);
    @(negedge clk);
    {acc_init, acc_load} = {a, 1'h1};
    issue({6'h05, d, 5'h06});
    `CHK("acc", d ? a : a & m, acc_q)
    `CHK("flags", {d, 2'h3, (a & m) == 0}, {wr_en_q, busy_q, zero_we_q, zero_q})
    `CHK("raddr", 5'h06, rd_addr)
    if (d) `CHK("wback", {5'h06, a & m}, {wr_addr_q, wr_data_q})
  endtask : t_and
  task automatic t_bits;
    for (int b = 0; b < 8; b++) begin
      issue({4'h4, 3'(b), 5'h1f});
      `CHK("clr", {1'h1, 5'h1f, m & ~(8'h01 << b)}, {wr_en_q, wr_addr_q, wr_data_q})
      issue({4'h5, 3'(b), 5'h1f});
      `CHK("set", {1'h0, m | (8'h01 << b)}, {zero_we_q, wr_data_q})
    end
  endtask : t_bits
  task automatic t_skip(input logic [2:0] b);
    logic hi;
    issue({4'h6, b, 5'h05});
    hi = m[b];
    `CHK("skip", !hi, skip_q)
    issue({4'h5, 3'h0, 5'h05});
    `CHK("void", {hi, hi, 1'h0}, {wr_en_q, busy_q, skip_q})
  endtask : t_skip
  task automatic t_foreign;
    logic [7:0] a;
    a = acc_q;
    issue({4'h7, 3'h7, 5'h05});
    `CHK("foreign", {a, 3'h0}, {acc_q, wr_en_q, zero_we_q, skip_q})
  endtask : t_foreign
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) if (++cyc > 400) begin
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_and(8'hf3, 1'h0);
    t_and(8'h5c, 1'h1);
    t_and(8'h5c, 1'h0);
    t_bits();
    t_skip(3'h0);
    t_skip(3'h5);
    t_foreign();
    report_and_stop();
  end
endmodule : tb_and_bit_ops_exec
bind abx_exec abx_exec_asserts i_abx_exec_asserts (.clk(clk), .rst(rst),
  .insn_valid(insn_valid), .acc_load(acc_load), .zero_q(zero_q), .zero_we_q(zero_we_q),
  .wr_en_q(wr_en_q), .skip_q(skip_q), .busy_q(busy_q), .insn(insn), .rd_data(rd_data),
  .acc_q(acc_q), .wr_data_q(wr_data_q));
`default_nettype wire
